// *** hdl/sso_pkg.sv ***
/*
 * Constants for the shared-bus SENT option logic: register indices, field
 * positions, reset values and tick timing.
 * Assumes a 100 MHz aclk and a register bus with 32-bit words.
 */
// Notes on behaviour
// - Slot marking enabled: drive bus high after each addressing pulse, length set by sensor id.
// - Slot marking disabled: never drive slot-marking highs after addressing pulses.
// - Zero-slot sampling enabled: sample and hold angle whenever slot counter resets to zero.
// - Zero-slot sampling disabled: slot counter reaching zero causes no sampling.
// - Threshold adjust acts only in long shared-bus mode (mode 7), adding 0 to 3 ticks.
// - Adjust field 00/01/10/11 gives minimum function pulse of 9/10/11/12 ticks.
// - Sample addressing on: sample pulses address, and apart from zero-slot sampling only a correctly addressed sensor samples.
package sso_pkg;
    // Register indices; byte address is four times the index
    localparam logic [5:0] REG_CFG_IDX = 6'h19;
    localparam logic [5:0] REG_SHARED_IDX = 6'h1B;
    localparam logic [5:0] REG_MODE_IDX = 6'h1C;
    localparam logic [5:0] REG_STAT_IDX = 6'h1D;

    // Configuration, shared and status word fields
    localparam int CFG_MARK_EN_BIT = 15;
    localparam int CFG_ZERO_EN_BIT = 2;
    localparam int CFG_ADDR_EN_BIT = 0;
    localparam int CFG_SID_LSB = 8;
    localparam int CFG_MAXID_LSB = 24;
    localparam int SHARED_ADJUST_LSB = 24;
    localparam int STAT_SLOT_LSB = 16;
    localparam int STAT_MARK_BIT = 20;

    localparam logic [31:0] CFG_RST = 32'h0000_0000;
    localparam logic [31:0] SHARED_RST = 32'h0000_0000;
    localparam logic [2:0] MODE_RST = 3'h0;
    localparam logic [31:0] CFG_WMASK = 32'h0300_8305;
    localparam logic [31:0] SHARED_WMASK = 32'h0300_0000;

    localparam logic [2:0] MODE_LONG_SHARED = 3'h7;

    // Pulse classification in ticks
    localparam logic [7:0] FP_BASE_TICKS = 8'h09;
    localparam logic [7:0] SAMPLE_MAX_TICKS = 8'h0F;
    localparam int SLOT_MARK_TICKS = 4;

    // Tick timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int TICK_NS = 3000;
    localparam int TICK_CYCLES = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : sso_pkg

// *** hdl/sso_pulse_meas.sv ***
/*
 * Measures each low pulse on the shared line in ticks and reports its width
 * at the rising edge that ends it.
 * Assumes the line input is already synchronous to aclk.
 */
module sso_pulse_meas
    import sso_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // Line and tick
    input wire logic tick,
    input wire logic line_in,
    // Result
    output logic done,
    output logic [7:0] width_r
);
    logic prev_r;
    logic [7:0] cnt_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            prev_r <= 1'b1;
            cnt_r <= 8'h00;
            done <= 1'b0;
            width_r <= 8'h00;
        end else if (ce) begin
            prev_r <= line_in;
            done <= 1'b0;
            if (!line_in && prev_r) begin
                // A tick on the falling edge counts, so a whole-tick pulse keeps its full width
                cnt_r <= tick ? 8'h01 : 8'h00;
            end else if (!line_in && tick && cnt_r != 8'hFF) begin
                // Saturate so long idle-low periods never alias to short pulses
                cnt_r <= cnt_r + 8'h01;
            end
            if (line_in && !prev_r) begin
                done <= 1'b1;
                width_r <= cnt_r;
            end
        end
    end
endmodule : sso_pulse_meas

// *** hdl/sso_top.sv ***
/*
 * Shared-bus SENT options: function pulse recognition with adjustable minimum,
 * slot counter, addressed and zero-slot sample-and-hold, slot marking, and an
 * AXI4-Lite register slave.
 * Assumes all inputs are synchronous to aclk; the bus wire is resolved outside.
 */
module sso_top
    import sso_pkg::*;
#(
    parameter int ANGLE_W = 12,
    parameter int TICK_DIV = TICK_CYCLES
) (
    // Clock, reset, enable
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // AXI4-Lite write
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // AXI4-Lite read
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Shared SENT line
    input wire logic sent_in,
    output logic sent_out,
    output logic sent_oe,
    // Angle path
    input wire logic [ANGLE_W-1:0] angle_in,
    output logic [ANGLE_W-1:0] angle_held_r,
    output logic sample_pulse
);
    logic [31:0] cfg_r;
    logic [31:0] shared_r;
    logic [2:0] mode_r;
    logic [15:0] tick_cnt_r;
    logic tick;
    logic meas_done;
    logic [7:0] meas_width;
    logic [7:0] min_width;
    logic is_func, is_sample, is_sync, addressing, slot_zero_ev, sample_ev;
    logic [1:0] slot_cnt_r;
    logic [1:0] sensor_id, max_id, thr_adj;
    logic mark_en, zero_en, addr_en, long_mode;
    logic [15:0] mark_cnt_r;
    logic mark_active;
    logic aw_got_r, w_got_r;
    logic [5:0] aw_idx_r;
    logic [31:0] w_data_r;
    logic [3:0] w_strb_r;
    logic [31:0] wmask;

    assign mark_en = cfg_r[CFG_MARK_EN_BIT];
    assign zero_en = cfg_r[CFG_ZERO_EN_BIT];
    assign addr_en = cfg_r[CFG_ADDR_EN_BIT];
    assign sensor_id = cfg_r[CFG_SID_LSB +: 2];
    assign max_id = cfg_r[CFG_MAXID_LSB +: 2];
    assign thr_adj = shared_r[SHARED_ADJUST_LSB +: 2];
    assign long_mode = (mode_r == MODE_LONG_SHARED);

    // Tick generator
    assign tick = (tick_cnt_r == 16'(TICK_DIV - 1));
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tick_cnt_r <= 16'h0000;
        end else if (ce) begin
            tick_cnt_r <= tick ? 16'h0000 : tick_cnt_r + 16'h0001;
        end
    end

    sso_pulse_meas u_meas (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .tick(tick),
        .line_in(sent_in),
        .done(meas_done),
        .width_r(meas_width)
    );

    // Adjustment only raises the floor in long mode; other modes keep the base
    assign min_width = long_mode ? FP_BASE_TICKS + {6'h00, thr_adj} : FP_BASE_TICKS;
    assign is_func = meas_done && (meas_width >= min_width);
    assign is_sample = is_func && (meas_width <= SAMPLE_MAX_TICKS);
    assign is_sync = is_func && (meas_width > SAMPLE_MAX_TICKS);
    assign addressing = is_sample && addr_en;
    assign slot_zero_ev = is_sync || (addressing && slot_cnt_r == max_id);
    assign sample_ev = (is_sample && (!addr_en || slot_cnt_r == sensor_id))
        || (zero_en && slot_zero_ev);
    assign sample_pulse = ce && sample_ev;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            slot_cnt_r <= 2'h0;
        end else if (ce) begin
            if (slot_zero_ev) begin
                slot_cnt_r <= 2'h0;
            end else if (addressing) begin
                slot_cnt_r <= slot_cnt_r + 2'h1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            angle_held_r <= '0;
        end else if (ce && sample_ev) begin
            angle_held_r <= angle_in;
        end
    end

    // Slot marking: later ids hold the line high longer
    assign mark_active = (mark_cnt_r != 16'h0000);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mark_cnt_r <= 16'h0000;
        end else if (ce) begin
            if (!mark_en) begin
                mark_cnt_r <= 16'h0000;
            end else if (addressing) begin
                mark_cnt_r <= 16'(({14'h0000, sensor_id} + 16'h0001) * SLOT_MARK_TICKS);
            end else if (mark_active && tick) begin
                mark_cnt_r <= mark_cnt_r - 16'h0001;
            end
        end
    end
    assign sent_out = mark_active;
    assign sent_oe = mark_active;

    // AXI4-Lite write path: address and data latched in either order
    assign awready = ce && !aw_got_r && !bvalid;
    assign wready = ce && !w_got_r && !bvalid;
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            wmask[8*i +: 8] = {8{w_strb_r[i]}};
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            aw_idx_r <= 6'h00;
            w_data_r <= 32'h0000_0000;
            w_strb_r <= 4'h0;
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
            cfg_r <= CFG_RST;
            shared_r <= SHARED_RST;
            mode_r <= MODE_RST;
        end else if (ce) begin
            if (awvalid && awready) begin
                aw_got_r <= 1'b1;
                aw_idx_r <= awaddr[7:2];
            end
            if (wvalid && wready) begin
                w_got_r <= 1'b1;
                w_data_r <= wdata;
                w_strb_r <= wstrb;
            end
            if (bvalid && bready) begin
                bvalid <= 1'b0;
            end
            if (aw_got_r && w_got_r && !bvalid) begin
                aw_got_r <= 1'b0;
                w_got_r <= 1'b0;
                bvalid <= 1'b1;
                bresp <= RESP_OKAY;
                unique case (aw_idx_r)
                    REG_CFG_IDX: cfg_r <= (cfg_r & ~(wmask & CFG_WMASK)) | (w_data_r & wmask & CFG_WMASK);
                    REG_SHARED_IDX: shared_r <= (shared_r & ~(wmask & SHARED_WMASK))
                        | (w_data_r & wmask & SHARED_WMASK);
                    REG_MODE_IDX: begin
                        if (w_strb_r[0]) begin
                            mode_r <= w_data_r[2:0];
                        end
                    end
                    REG_STAT_IDX: bresp <= RESP_OKAY;
                    default: bresp <= RESP_SLVERR;
                endcase
            end
        end
    end

    // AXI4-Lite read path
    assign arready = ce && !rvalid;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= RESP_OKAY;
        end else if (ce) begin
            if (rvalid && rready) begin
                rvalid <= 1'b0;
            end
            if (arvalid && arready) begin
                rvalid <= 1'b1;
                rresp <= RESP_OKAY;
                rdata <= 32'h0000_0000;
                unique case (araddr[7:2])
                    REG_CFG_IDX: rdata <= cfg_r;
                    REG_SHARED_IDX: rdata <= shared_r;
                    REG_MODE_IDX: rdata <= {29'h0000_0000, mode_r};
                    REG_STAT_IDX: begin
                        rdata[ANGLE_W-1:0] <= angle_held_r;
                        rdata[STAT_SLOT_LSB +: 2] <= slot_cnt_r;
                        rdata[STAT_MARK_BIT] <= mark_active;
                    end
                    default: rresp <= RESP_SLVERR;
                endcase
            end
        end
    end

    // Checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_addr_marked;
        ce && addressing && mark_en;
    endsequence
    sequence s_mark_running;
        mark_active ##1 mark_active;
    endsequence

    a_mark_after_addr: assert property (s_addr_marked |=> s_mark_running)
        else $error("slot mark not driven after addressing pulse");
    a_mark_disabled: assert property (ce && !mark_en |=> !sent_oe)
        else $error("slot mark driven while disabled");
    a_zero_sample: assert property (ce && zero_en && slot_zero_ev |=> angle_held_r == $past(angle_in))
        else $error("no hold at slot zero");
    a_zero_idle: assert property (ce && !zero_en && is_sync |=> $stable(angle_held_r) && slot_cnt_r == 2'h0)
        else $error("zero slot acted while disabled");
    a_long_floor: assert property (
        meas_done && long_mode && meas_width < 8'h09 + {6'h00, thr_adj} |-> !is_func)
        else $error("short pulse accepted in long mode");
    a_min_table: assert property (
        meas_done && long_mode && meas_width == 8'h09 + {6'h00, thr_adj} |-> is_func)
        else $error("minimum width pulse rejected");
    a_short_ignored: assert property (
        ce && meas_done && long_mode && meas_width < min_width |=> $stable(slot_cnt_r) && $stable(angle_held_r))
        else $error("short pulse had effect");
    a_addr_mismatch: assert property (
        ce && is_sample && addr_en && !zero_en && slot_cnt_r != sensor_id |=> $stable(angle_held_r))
        else $error("held while not addressed");
    a_bvalid_hold: assert property (bvalid && !bready |=> bvalid)
        else $error("bvalid dropped early");
endmodule : sso_top

// *** verif/sso_ctrl_model.sv ***
/*
 * Far-end controller on the shared line: sends low pulses a whole
 * number of ticks long.
 * Assumes a pull-up returns the line high once it is released.
 */
module sso_ctrl_model #(
    parameter int TDIV = 4
) (
    // Clock
    input wire logic aclk,
    // Shared line
    input wire logic sent_oe,
    output logic line_low
);
    timeunit 1ns;
    timeprecision 1ps;
    initial line_low = 1'b0;
    // Never pulls low against an active slot mark
    task send(input int w);
        while (sent_oe) @(negedge aclk);
        @(posedge aclk);
        line_low <= 1'b1;
        repeat (w * TDIV) @(posedge aclk);
        line_low <= 1'b0;
    endtask : send
endmodule : sso_ctrl_model

// *** verif/tb_shared_sent_slot_options.sv ***
/*
 * Bench for sso_top: registers, pulse thresholds, addressing,
 * zero-slot sampling and slot marking against an integer model.
 * Assumes sso_ctrl_model as the far end and a pull-up on the line.
 */
module tb_shared_sent_slot_options import sso_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int TD = 4;
    localparam logic [7:0] A_CFG = {REG_CFG_IDX, 2'b00};
    localparam logic [7:0] A_SS = {REG_SHARED_IDX, 2'b00};
    localparam logic [7:0] A_MODE = {REG_MODE_IDX, 2'b00};
    localparam logic [7:0] A_ST = {REG_STAT_IDX, 2'b00};
    logic aclk = 0, aresetn = 0;
    logic [7:0] awaddr = 0, araddr = 0;
    logic awvalid = 0, wvalid = 0, bready = 1, arvalid = 0, rready = 1;
    logic ce = 1;
    logic [31:0] wdata = 0, rdata, lf = 32'h6deb_ae49;
    logic [3:0] wstrb = 4'hf;
    logic [1:0] bresp, rresp;
    logic awready, wready, bvalid, arready, rvalid;
    logic sent_in, sent_out, sent_oe, line_low, sample_pulse;
    logic [11:0] angle_in = 0, angle_held_r;
    int error_cnt = 0, samples_checked = 0, sp_n = 0, oe_n = 0, sp_ce = 0;
    int m_cfg, m_ss, m_mode, m_slot = 0, m_ang = 0;
    assign sent_in = line_low ? 1'b0 : (sent_oe ? sent_out : 1'b1);
    sso_top #(.TICK_DIV(TD)) dut (.aclk, .aresetn, .ce, .awaddr,
        .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp,
        .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
        .rvalid, .rready, .sent_in, .sent_out, .sent_oe, .angle_in,
        .angle_held_r, .sample_pulse);
    sso_ctrl_model #(.TDIV(TD)) ctrl (.aclk, .sent_oe, .line_low);
    initial forever #5 aclk = ~aclk;
    always @(posedge aclk) begin
        if (sample_pulse === 1'b1) sp_n <= sp_n + 1;
        if (sent_oe === 1'b1 && sent_out === 1'b1) oe_n <= oe_n + 1;
    end
    function logic [31:0] nx(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : nx
    task summarize();
        $display("checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : summarize
    task chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t got %h want %h", $time, got, exp);
        end
    endtask : chk
    task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        logic ta, tw, pa, pw;
        ta = 0;
        tw = 0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (!(ta && tw)) begin
            @(negedge aclk);
            pa = awvalid && awready;
            pw = wvalid && wready;
            @(posedge aclk);
            if (pa) awvalid <= 1'b0;
            if (pw) wvalid <= 1'b0;
            ta |= pa;
            tw |= pw;
        end
        do @(negedge aclk); while (!bvalid);
        chk(bresp, r);
        @(posedge aclk);
    endtask : wr
    task rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        araddr <= a;
        arvalid <= 1'b1;
        do @(negedge aclk); while (!arready);
        @(posedge aclk);
        arvalid <= 1'b0;
        do @(negedge aclk); while (!rvalid);
        chk(rdata, d);
        chk(rresp, r);
        @(posedge aclk);
    endtask : rd
    task setc(input logic [31:0] c, input logic [31:0] s, input logic [2:0] m);
        wr(A_CFG, c, RESP_OKAY);
        wr(A_SS, s, RESP_OKAY);
        wr(A_MODE, {29'h0, m}, RESP_OKAY);
        m_cfg = c;
        m_ss = s;
        m_mode = m;
    endtask : setc
    // One low pulse of w ticks, then model update and comparison
    task pulse(input int w);
        int s0, o0, mn, ml, d;
        logic hold, mark, lo;
        lf = nx(lf);
        angle_in <= lf[11:0];
        s0 = sp_n;
        o0 = oe_n;
        ctrl.send(w);
        repeat (4) @(posedge aclk);
        while (sent_oe) @(negedge aclk);
        @(posedge aclk);
        mn = 9 + (m_mode == 7 ? m_ss[25:24] : 0);
        hold = 0;
        mark = 0;
        lo = 0;
        if (w >= mn && w <= 15) begin
            hold = !m_cfg[0] || m_slot == m_cfg[9:8];
            if (m_cfg[0]) begin
                mark = m_cfg[15];
                lo = m_slot == m_cfg[25:24];
                m_slot = lo ? 0 : m_slot + 1;
            end
        end else if (w > 15) begin
            lo = 1;
            m_slot = 0;
        end
        hold |= lo && m_cfg[2];
        if (hold) m_ang = lf[11:0];
        ml = (m_cfg[9:8] + 1) * 4 * TD;
        d = oe_n - o0;
        chk(sp_n - s0, hold);
        chk(angle_held_r, m_ang);
        // The mark starts between tick edges, so the first tick may be partial
        if (mark) chk(d > ml - TD && d <= ml, 1);
        else chk(d, 0);
        rd(A_ST, m_slot << 16 | m_ang, RESP_OKAY);
    endtask : pulse
    initial begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(A_CFG, CFG_RST, RESP_OKAY);
        rd(A_SS, SHARED_RST, RESP_OKAY);
        rd(A_MODE, 0, RESP_OKAY);
        wr(A_CFG, '1, RESP_OKAY);
        rd(A_CFG, CFG_WMASK, RESP_OKAY);
        wr(A_SS, '1, RESP_OKAY);
        rd(A_SS, SHARED_WMASK, RESP_OKAY);
        wr(8'h00, '1, RESP_SLVERR);
        rd(8'h00, 0, RESP_SLVERR);
        wr(A_ST, '1, RESP_OKAY);
        rd(A_ST, 0, RESP_OKAY);
        // Every adjust code, just below and at the minimum
        for (int a = 0; a < 4; a++) begin
            setc(0, a << 24, MODE_LONG_SHARED);
            pulse(8 + a);
            pulse(9 + a);
        end
        rd(A_MODE, 7, RESP_OKAY);
        setc(0, 32'h0300_0000, 3'h0);
        pulse(9);
        pulse(8);
        setc(32'h0100_8101, 0, MODE_LONG_SHARED);
        pulse(20);
        pulse(12);
        pulse(12);
        setc(32'h0100_8005, 0, MODE_LONG_SHARED);
        pulse(12);
        pulse(12);
        pulse(20);
        setc(32'h0100_0101, 0, MODE_LONG_SHARED);
        pulse(12);
        pulse(12);
        setc(32'h0300_8205, 32'h0200_0000, MODE_LONG_SHARED);
        repeat (8) pulse(8 + lf[19:16]);
        // A frozen block must not see a pulse sent while its enable is low
        ce <= 1'b0;
        sp_ce = sp_n;
        ctrl.send(12);
        repeat (4) @(posedge aclk);
        ce <= 1'b1;
        repeat (4) @(posedge aclk);
        chk(sp_n - sp_ce, 0);
        rd(A_ST, m_slot << 16 | m_ang, RESP_OKAY);
        summarize();
    end
    initial begin
        repeat (30000) @(posedge aclk);
        error_cnt++;
        summarize();
    end
endmodule : tb_shared_sent_slot_options
